// ===== rtl/micp_defines.svh
`ifndef MICP_DEFINES_SVH
`define MICP_DEFINES_SVH

`define MICP_OFS_CTRL      8'h00
`define MICP_OFS_ADDR      8'h04
`define MICP_OFS_END       8'h08
`define MICP_OFS_WDATA     8'h0c
`define MICP_OFS_RDATA     8'h10
`define MICP_OFS_STATUS    8'h14

`define MICP_CTRL_START    0
`define MICP_CTRL_WRITE    1
`define MICP_CTRL_RIGHT    2
`define MICP_CTRL_LEFT     3
`define MICP_CTRL_MULDIV   4

`define MICP_ST_BUSY       0
`define MICP_ST_DONE       1
`define MICP_ST_ACK        2
`define MICP_ST_QUIESCENT  3
`define MICP_ST_LOCKOUT    4
`define MICP_ST_ACK_LATE   5

`define MICP_RST_WORD      16'h0000
`define MICP_RST_CTRL      3'h0

`define MICP_CLK_PERIOD_NS 40
`define MICP_ACK_MAX_NS    13000
`define MICP_ACK_MAX_CYC   (`MICP_ACK_MAX_NS / `MICP_CLK_PERIOD_NS)

`endif

// ===== rtl/micp_pkg.sv
package micp_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_REQ  = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_CYC0 = 6'b001000,
    ST_CYC1 = 6'b010000,
    ST_CYC3 = 6'b100000
  } micp_state_t;

  // micro-operations toward the processor, true = asserted
  typedef struct packed {
    logic mem_cycle;
    logic left_byte;
    logic right_byte;
    logic data_clear;
    logic accum_inhibit;
    logic io_to_operand;
    logic func_to_addr;
    logic func_to_data;
  } micp_uop_t;

endpackage

// ===== rtl/micp_host.sv
// Operation
// [RULE_01] idle request flop changes only at slot zero
// [RULE_02] no memory cycle before idle acknowledge
// [RULE_03] drop idle request at last cycle's slot zero
// [RULE_04] processor acknowledges within one to thirteen microseconds
// [RULE_05] processor refuses idle after single-cycle instruction
// [RULE_06] quiescent processor lets channel cycle memory anyway
// [RULE_07] no idle request during multiply or divide
// [RULE_08] lockout updates at fetch, slot three, second phase
// [RULE_09] memory cycle request pulses during slot zero
// [RULE_10] left strobe slot zero, right strobe slot one
// [RULE_11] full-word write pulses no byte strobe
// [RULE_12] clear data register whenever a byte is read
// [RULE_13] address load: inhibit, two gates at slot zero
// [RULE_14] function bus input needs external byte positioning
// [RULE_15] programmed io bus carries address and data in
// [RULE_16] function bus output offers no byte unpacking
// [RULE_17] direct data register output gives earliest read
// [RULE_18] suffix n means true low, p true high
// [RULE_19] end address compared by channel itself
// [RULE_20] write data loaded at slot one only
// [RULE_21] read data valid at slot three
// [RULE_22] micro-operations follow slot pulses exactly
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "micp_defines.svh"

module micp_host #(
  parameter int AW           = 16,
  parameter int ACK_MAX_CYC  = `MICP_ACK_MAX_CYC
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic          PSEL_I,
  input  wire logic          PENABLE_I,
  input  wire logic          PWRITE_I,
  input  wire logic [7:0]    PADDR_I,
  input  wire logic [31:0]   PWDATA_I,
  output logic      [31:0]   PRDATA_O,
  output logic               PREADY_O,
  output logic               PSLVERR_O,
  input  wire logic          SLOT_ZERO_PULSE_N_I,
  input  wire logic          SLOT_ONE_PULSE_N_I,
  input  wire logic          SLOT_THREE_PULSE_N_I,
  input  wire logic          SECOND_PHASE_CLOCK_N_I,
  input  wire logic          IDLE_ACKNOWLEDGE_N_I,
  input  wire logic          QUIESCENT_STATUS_I,
  input  wire logic          MULTIPLY_DECODE_N_I,
  input  wire logic          DIVIDE_DECODE_N_I,
  input  wire logic          FETCH_STATE_FLAG_I,
  input  wire logic [15:0]   DATA_REG_OUT_N_I,
  output logic               IDLE_REQUEST_FF_N_O,
  output logic               MEMORY_CYCLE_REQUEST_N_O,
  output logic               LEFT_BYTE_STROBE_N_O,
  output logic               RIGHT_BYTE_STROBE_N_O,
  output logic               DATA_REG_CLEAR_N_O,
  output logic               ACCUM_GATE_INHIBIT_N_O,
  output logic               IO_BUS_TO_OPERAND_GATE_N_O,
  output logic               FUNCTION_TO_ADDRESS_GATE_N_O,
  output logic               FUNCTION_TO_DATA_GATE_N_O,
  output logic [15:0]        IO_DATA_N_O,
  output logic               IO_DATA_OE_O
);

  micp_pkg::micp_state_t state_reg;
  micp_pkg::micp_uop_t   uop_reg;
  micp_pkg::micp_uop_t   uop_next;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] end_reg;
  logic [15:0]   wdata_reg;
  logic [15:0]   rdata_reg;
  logic [15:0]   io_data_reg;
  logic [15:0]   io_data_next;
  logic          io_oe_reg;
  logic          write_reg;
  logic [1:0]    bytes_reg;
  logic          muldiv_reg;
  logic          done_reg;
  logic          idle_req_reg;
  logic          lockout_reg;
  logic          last_reg;
  logic          ack_late_reg;
  logic [15:0]   wait_cnt_reg;
  logic          s0_prev_reg;
  logic          s1_prev_reg;
  logic          s3_prev_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [31:0]   prdata_reg;

  logic s0, s1, s3, cb, ack, s0_rise, s0_fall, s1_fall, s3_fall;
  logic acc, wr, mapped, start, cyc_go;

  // active-low pins turned into true-high levels
  assign s0 = ~SLOT_ZERO_PULSE_N_I;      // RULE_18
  assign s1 = ~SLOT_ONE_PULSE_N_I;
  assign s3 = ~SLOT_THREE_PULSE_N_I;
  assign cb = ~SECOND_PHASE_CLOCK_N_I;
  assign ack = ~IDLE_ACKNOWLEDGE_N_I;
  assign s0_rise = s0 & ~s0_prev_reg;
  assign s0_fall = ~s0 & s0_prev_reg;
  assign s1_fall = ~s1 & s1_prev_reg;
  assign s3_fall = ~s3 & s3_prev_reg;

  // register bus: one wait cycle, answer registered
  assign acc = PSEL_I & PENABLE_I & ~pready_reg;
  assign wr = acc & PWRITE_I;
  assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `MICP_OFS_STATUS);
  assign start = wr && mapped && PADDR_I == `MICP_OFS_CTRL
                 && PWDATA_I[`MICP_CTRL_START]
                 && state_reg == micp_pkg::ST_IDLE;

  // granted slot zero; slot-zero ops start here, not one clock later
  assign cyc_go = state_reg == micp_pkg::ST_WAIT && s0_rise
                  && (ack || QUIESCENT_STATUS_I);        // RULE_02 RULE_06

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & ~mapped;
      prdata_reg  <= 32'h0000_0000;
      if (acc && !PWRITE_I && mapped) begin
        case (PADDR_I)
          `MICP_OFS_CTRL: begin
            prdata_reg[`MICP_CTRL_WRITE]  <= write_reg;
            prdata_reg[`MICP_CTRL_RIGHT]  <= bytes_reg[0];
            prdata_reg[`MICP_CTRL_LEFT]   <= bytes_reg[1];
            prdata_reg[`MICP_CTRL_MULDIV] <= muldiv_reg;
          end
          `MICP_OFS_ADDR:  prdata_reg[AW-1:0] <= addr_reg;
          `MICP_OFS_END:   prdata_reg[AW-1:0] <= end_reg;
          `MICP_OFS_WDATA: prdata_reg[15:0] <= wdata_reg;
          `MICP_OFS_RDATA: prdata_reg[15:0] <= rdata_reg;
          `MICP_OFS_STATUS: begin
            prdata_reg[`MICP_ST_BUSY]      <= state_reg != micp_pkg::ST_IDLE;
            prdata_reg[`MICP_ST_DONE]      <= done_reg;
            prdata_reg[`MICP_ST_ACK]       <= ack;
            prdata_reg[`MICP_ST_QUIESCENT] <= QUIESCENT_STATUS_I;
            prdata_reg[`MICP_ST_LOCKOUT]   <= lockout_reg;
            prdata_reg[`MICP_ST_ACK_LATE]  <= ack_late_reg;
          end
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control and block bounds; writes ignored while a block runs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      {write_reg, bytes_reg} <= `MICP_RST_CTRL;
      muldiv_reg <= 1'b0;
      end_reg    <= AW'(`MICP_RST_WORD);
      wdata_reg  <= `MICP_RST_WORD;
    end else if (wr && state_reg == micp_pkg::ST_IDLE) begin
      case (PADDR_I)
        `MICP_OFS_CTRL: begin
          write_reg  <= PWDATA_I[`MICP_CTRL_WRITE];
          bytes_reg  <= {PWDATA_I[`MICP_CTRL_LEFT], PWDATA_I[`MICP_CTRL_RIGHT]};
          muldiv_reg <= PWDATA_I[`MICP_CTRL_MULDIV];
        end
        `MICP_OFS_END:   end_reg <= PWDATA_I[AW-1:0];
        `MICP_OFS_WDATA: wdata_reg <= PWDATA_I[15:0];
        default: ;
      endcase
    end
  end

  // slot level history for edge detection
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s0_prev_reg <= 1'b0;
      s1_prev_reg <= 1'b0;
      s3_prev_reg <= 1'b0;
    end else begin
      s0_prev_reg <= s0;
      s1_prev_reg <= s1;
      s3_prev_reg <= s3;
    end
  end

  // multiply/divide lockout, sampled in fetch at slot three phase two
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      lockout_reg <= 1'b0;
    end else if (FETCH_STATE_FLAG_I && s3 && cb) begin  // RULE_08
      lockout_reg <= ~MULTIPLY_DECODE_N_I | ~DIVIDE_DECODE_N_I;  // RULE_07
    end
  end

  // block sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_reg    <= micp_pkg::ST_IDLE;
      idle_req_reg <= 1'b0;
      last_reg     <= 1'b0;
      done_reg     <= 1'b0;
      addr_reg     <= AW'(`MICP_RST_WORD);
      rdata_reg    <= `MICP_RST_WORD;
    end else begin
      if (wr && PADDR_I == `MICP_OFS_STATUS && PWDATA_I[`MICP_ST_DONE])
        done_reg <= 1'b0;
      if (wr && PADDR_I == `MICP_OFS_ADDR && state_reg == micp_pkg::ST_IDLE)
        addr_reg <= PWDATA_I[AW-1:0];
      case (state_reg)
        micp_pkg::ST_IDLE: begin
          if (start) begin
            done_reg  <= 1'b0;
            state_reg <= micp_pkg::ST_REQ;
          end
        end
        micp_pkg::ST_REQ: begin
          if (s0_rise && !(muldiv_reg && lockout_reg)) begin  // RULE_07
            idle_req_reg <= 1'b1;                            // RULE_01
            state_reg    <= micp_pkg::ST_WAIT;
          end
        end
        micp_pkg::ST_WAIT: begin
          // idle granted, or quiescent processor held by our request
          if (cyc_go) begin                                  // RULE_02 RULE_06
            last_reg  <= addr_reg == end_reg;                // RULE_19
            if (addr_reg == end_reg)
              idle_req_reg <= 1'b0;                          // RULE_03
            state_reg <= micp_pkg::ST_CYC0;
          end
        end
        micp_pkg::ST_CYC0: begin
          if (s0_fall)
            state_reg <= micp_pkg::ST_CYC1;
        end
        micp_pkg::ST_CYC1: begin
          if (s1_fall)
            state_reg <= micp_pkg::ST_CYC3;
        end
        micp_pkg::ST_CYC3: begin
          if (s3 && !write_reg)
            rdata_reg <= ~DATA_REG_OUT_N_I;                  // RULE_17 RULE_21
          if (s3_fall) begin
            addr_reg  <= addr_reg + 1'b1;
            if (last_reg) begin
              done_reg  <= 1'b1;
              state_reg <= micp_pkg::ST_IDLE;
            end else begin
              state_reg <= micp_pkg::ST_WAIT;
            end
          end
        end
        default: state_reg <= micp_pkg::ST_IDLE;
      endcase
    end
  end

  // idle grant watchdog, flags an overlong wait without aborting
  always_ff @(posedge CLK_I) begin
    if (RST_I || start) begin
      wait_cnt_reg <= 16'h0000;
      ack_late_reg <= 1'b0;
    end else if (state_reg == micp_pkg::ST_WAIT && !ack
                 && !QUIESCENT_STATUS_I) begin
      if (wait_cnt_reg >= 16'(ACK_MAX_CYC))
        ack_late_reg <= 1'b1;                                // RULE_04
      else
        wait_cnt_reg <= wait_cnt_reg + 16'h0001;
    end
  end

  // micro-operations track the slot levels of the active phase
  always_comb begin
    uop_next     = '0;
    io_data_next = 16'hffff;
    if ((state_reg == micp_pkg::ST_CYC0 || cyc_go) && s0) begin  // RULE_22
      uop_next.mem_cycle     = 1'b1;                         // RULE_09
      uop_next.accum_inhibit = 1'b1;                         // RULE_13
      uop_next.io_to_operand = 1'b1;
      uop_next.func_to_addr  = 1'b1;
      uop_next.left_byte     = bytes_reg[1];                 // RULE_10
      uop_next.data_clear    = |bytes_reg;                   // RULE_12
      io_data_next = ~16'(addr_reg);                         // RULE_15
    end
    // slot one may open in the clock that closes slot zero
    if ((state_reg == micp_pkg::ST_CYC0 || state_reg == micp_pkg::ST_CYC1)
        && s1) begin
      uop_next.right_byte = bytes_reg[0];                    // RULE_10 RULE_11
      if (write_reg) begin
        uop_next.accum_inhibit = 1'b1;
        uop_next.io_to_operand = 1'b1;
        uop_next.func_to_data  = 1'b1;                       // RULE_20
        io_data_next = ~wdata_reg;                           // RULE_14
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      uop_reg     <= '0;
      io_data_reg <= 16'hffff;
      io_oe_reg   <= 1'b0;
    end else begin
      uop_reg     <= uop_next;
      io_data_reg <= io_data_next;
      io_oe_reg   <= uop_next.io_to_operand;
    end
  end

  assign PRDATA_O                     = prdata_reg;
  assign PREADY_O                     = pready_reg;
  assign PSLVERR_O                    = pslverr_reg;
  assign IDLE_REQUEST_FF_N_O          = ~idle_req_reg;
  assign MEMORY_CYCLE_REQUEST_N_O     = ~uop_reg.mem_cycle;
  assign LEFT_BYTE_STROBE_N_O         = ~uop_reg.left_byte;
  assign RIGHT_BYTE_STROBE_N_O        = ~uop_reg.right_byte;
  assign DATA_REG_CLEAR_N_O           = ~uop_reg.data_clear;
  assign ACCUM_GATE_INHIBIT_N_O       = ~uop_reg.accum_inhibit;
  assign IO_BUS_TO_OPERAND_GATE_N_O   = ~uop_reg.io_to_operand;
  assign FUNCTION_TO_ADDRESS_GATE_N_O = ~uop_reg.func_to_addr;
  assign FUNCTION_TO_DATA_GATE_N_O    = ~uop_reg.func_to_data;
  assign IO_DATA_N_O                  = io_data_reg;
  assign IO_DATA_OE_O                 = io_oe_reg;

  default clocking cb_main @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_idle_req_slot: assert property (          // RULE_01
    $changed(idle_req_reg) |-> $past(s0_rise))
    else $error("idle request changed off slot zero");

  a_cycle_after_ack: assert property (         // RULE_02
    $rose(uop_reg.mem_cycle) |-> $past(ack || QUIESCENT_STATUS_I))
    else $error("memory cycle without idle grant");

  a_release_last: assert property (            // RULE_03
    $fell(idle_req_reg) |=> uop_reg.mem_cycle && last_reg)
    else $error("idle released away from last cycle");

  a_lockout_req: assert property (             // RULE_07
    $rose(idle_req_reg) |-> !($past(muldiv_reg) && $past(lockout_reg)))
    else $error("idle request raised under lockout");

  a_lockout_time: assert property (            // RULE_08
    $changed(lockout_reg) |-> $past(FETCH_STATE_FLAG_I && s3 && cb))
    else $error("lockout changed off fetch slot three");

  a_cycle_slot0: assert property (             // RULE_09
    uop_reg.mem_cycle
      |-> $past(s0) && $past(state_reg == micp_pkg::ST_CYC0 || cyc_go))
    else $error("cycle request outside slot zero");

  a_right_slot1: assert property (             // RULE_10
    uop_reg.right_byte |-> $past(s1) && !uop_reg.mem_cycle)
    else $error("right strobe outside slot one");

  a_word_write: assert property (              // RULE_11
    write_reg && bytes_reg == 2'b00
      |-> !uop_reg.left_byte && !uop_reg.right_byte)
    else $error("byte strobe on full word write");

  a_clear_read: assert property (              // RULE_12
    $rose(uop_reg.mem_cycle) && bytes_reg != 2'b00 |-> uop_reg.data_clear)
    else $error("byte read without data clear");

  a_addr_gates: assert property (              // RULE_13
    uop_reg.func_to_addr |-> uop_reg.accum_inhibit && uop_reg.io_to_operand
                             && io_oe_reg && uop_reg.mem_cycle)
    else $error("address load gates incomplete");

  a_data_slot1: assert property (              // RULE_20
    uop_reg.func_to_data |-> $past(s1) && write_reg && !uop_reg.func_to_addr)
    else $error("data load outside slot one");

  a_slot_span: assert property (               // RULE_22
    $fell(s0) && state_reg == micp_pkg::ST_CYC0 |=> !uop_reg.mem_cycle)
    else $error("cycle request outlives slot zero");

  a_slot_open: assert property (               // RULE_22
    cyc_go |=> uop_reg.mem_cycle && uop_reg.func_to_addr)
    else $error("cycle request late after slot zero");

endmodule

// ===== testbench/micp_proc_model.sv
`timescale 1ns/1ps
module micp_proc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  ack_dly_i,
  input  wire logic        quiet_i,
  input  wire logic        idle_req_n_i,
  input  wire logic        addr_gate_n_i,
  input  wire logic        data_gate_n_i,
  input  wire logic        io_oe_i,
  input  wire logic [15:0] io_n_i,
  output logic             s0_n_o,
  output logic             s1_n_o,
  output logic             s3_n_o,
  output logic             cb_n_o,
  output logic             ack_n_o,
  output logic [15:0]      dreg_n_o,
  output logic [15:0]      m_reg_o,
  output logic [15:0]      w_word_o
);
  logic [4:0] cnt_reg;
  logic [7:0] wait_reg;

  // four slots of six clocks each
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_reg == 5'h17) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  assign s0_n_o = cnt_reg > 5'h05;
  assign s1_n_o = (cnt_reg < 5'h06) || (cnt_reg > 5'h0b);
  assign s3_n_o = cnt_reg < 5'h12;
  assign cb_n_o = (cnt_reg % 5'h06) < 5'h03;
  // whole word only, noise outside slot three
  assign dreg_n_o = s3_n_o ? {{3{cnt_reg}}, 1'b0}
                           : ~(m_reg_o ^ 16'h5a5a);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_reg_o  <= 16'h0000;
      w_word_o <= 16'h0000;
    end else begin
      if (!addr_gate_n_i && io_oe_i && !s0_n_o) begin
        m_reg_o <= ~io_n_i;
      end
      if (!data_gate_n_i && io_oe_i && !s1_n_o) begin
        w_word_o <= ~io_n_i;
      end
    end
  end

  // ack only at a boundary, 25 clocks at the earliest; none if quiescent
  always_ff @(posedge clk_i) begin
    if (rst_i || idle_req_n_i) begin
      wait_reg <= 8'h00;
      ack_n_o  <= 1'b1;
    end else if (!quiet_i) begin
      wait_reg <= wait_reg + {7'h00, wait_reg != 8'hff};
      if (wait_reg >= ack_dly_i && wait_reg > 8'h18 && cnt_reg == 5'h00) begin
        ack_n_o <= 1'b0;
      end
    end
  end
endmodule

// ===== testbench/memory_interleave_channel_port_bench.sv
`timescale 1ns/1ps
module memory_interleave_channel_port_bench;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, oe;
  logic        quiet, fetch, mul_n, acked, s0_n, s1_n, s3_n, cb_n, ack_n;
  logic        idle_n, mc_n, lb_n, rb_n, clr_n, fa_n, fd_n, ai_n, op_n;
  logic        p_mc, p_lb, p_rb, p_clr, p_idle, p_fa, p_fd, div_n;
  logic [7:0]  paddr, ack_dly;
  logic [15:0] dreg_n, io_n, m_reg, w_word;
  logic [31:0] pwdata, prdata, q;
  int          fail_count, comparisons, n_mc, n_lb, n_rb, n_clr;

  micp_host #(.ACK_MAX_CYC(60)) dut_u (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SLOT_ZERO_PULSE_N_I(s0_n), .SLOT_ONE_PULSE_N_I(s1_n),
    .SLOT_THREE_PULSE_N_I(s3_n), .SECOND_PHASE_CLOCK_N_I(cb_n),
    .IDLE_ACKNOWLEDGE_N_I(ack_n), .QUIESCENT_STATUS_I(quiet),
    .MULTIPLY_DECODE_N_I(mul_n), .DIVIDE_DECODE_N_I(div_n),
    .FETCH_STATE_FLAG_I(fetch), .DATA_REG_OUT_N_I(dreg_n),
    .IDLE_REQUEST_FF_N_O(idle_n), .MEMORY_CYCLE_REQUEST_N_O(mc_n),
    .LEFT_BYTE_STROBE_N_O(lb_n), .RIGHT_BYTE_STROBE_N_O(rb_n),
    .DATA_REG_CLEAR_N_O(clr_n), .ACCUM_GATE_INHIBIT_N_O(ai_n),
    .IO_BUS_TO_OPERAND_GATE_N_O(op_n), .FUNCTION_TO_ADDRESS_GATE_N_O(fa_n),
    .FUNCTION_TO_DATA_GATE_N_O(fd_n), .IO_DATA_N_O(io_n),
    .IO_DATA_OE_O(oe));

  micp_proc_model proc_u (
    .clk_i(clk), .rst_i(rst), .ack_dly_i(ack_dly), .quiet_i(quiet),
    .idle_req_n_i(idle_n), .addr_gate_n_i(fa_n), .data_gate_n_i(fd_n),
    .io_oe_i(oe), .io_n_i(io_n), .s0_n_o(s0_n), .s1_n_o(s1_n),
    .s3_n_o(s3_n), .cb_n_o(cb_n), .ack_n_o(ack_n), .dreg_n_o(dreg_n),
    .m_reg_o(m_reg), .w_word_o(w_word));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    @(posedge clk);
  endtask

  task automatic wait_done();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, 8'h14, 32'h0);
      if (q[1] === 1'b1) return;
    end
    fail_count++;
    results();
  endtask

  task automatic go(input logic [15:0] a, input logic [15:0] e,
                    input logic [7:0] c);
    apb(1'b1, 8'h04, {16'h0, a});
    apb(1'b1, 8'h08, {16'h0, e});
    n_mc = 0;
    n_lb = 0;
    n_rb = 0;
    n_clr = 0;
    acked = 1'b0;
    apb(1'b1, 8'h00, {24'h0, c});
  endtask

  // edge counts and slot alignment of the pulses
  always @(posedge clk) begin
    p_mc <= mc_n;
    p_lb <= lb_n;
    p_rb <= rb_n;
    p_clr <= clr_n;
    p_idle <= idle_n;
    p_fa <= fa_n;
    p_fd <= fd_n;
    if (p_fa && !fa_n) chk({ai_n, op_n, s0_n}, 3'h0);
    if (p_fd && !fd_n) chk({ai_n, op_n, s1_n}, 3'h0);
    if (!ack_n) acked <= 1'b1;
    if (p_mc && !mc_n) begin
      n_mc++;
      chk(s0_n, 1'b0);
      chk(acked | quiet, 1'b1);
    end
    if (p_lb && !lb_n) begin
      n_lb++;
      chk(s0_n, 1'b0);
    end
    if (p_rb && !rb_n) begin
      n_rb++;
      chk(s1_n, 1'b0);
    end
    if (p_clr && !clr_n) begin
      n_clr++;
      chk(s0_n, 1'b0);
    end
    if (!rst && p_idle !== idle_n) chk(s0_n, 1'b0);
  end

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    chk({idle_n, mc_n, lb_n, rb_n, clr_n, oe}, 6'h3e);
    $display("reset test done");
  endtask

  task automatic t_read();
    go(16'h0010, 16'h0011, 8'h0d);
    wait_done();
    chk(q[5], 1'b0);
    chk(n_mc, 2);
    chk(n_lb + n_rb, 4);
    chk(n_clr, 2);
    chk(idle_n, 1'b1);
    chk(m_reg, 16'h0011);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h5a4b);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0012);
    $display("read test done");
  endtask

  task automatic t_write();
    apb(1'b1, 8'h0c, 32'h0000beef);
    go(16'h0020, 16'h0020, 8'h03);
    wait_done();
    chk(n_mc, 1);
    chk(n_lb + n_rb + n_clr, 0);
    chk(w_word, 16'hbeef);
    chk(m_reg, 16'h0020);
    $display("write test done");
  endtask

  task automatic t_quiet();
    quiet <= 1'b1;
    go(16'h0030, 16'h0030, 8'h09);
    wait_done();
    chk(q[3], 1'b1);
    chk(acked, 1'b0);
    chk(n_mc + n_lb + n_clr, 3);
    chk(n_rb, 0);
    quiet <= 1'b0;
    $display("quiescent test done");
  endtask

  task automatic t_slow();
    ack_dly <= 8'h64;
    go(16'h0040, 16'h0040, 8'h05);
    apb(1'b1, 8'h04, 32'h0077);
    for (int i = 0; i < 60 && q[5] !== 1'b1; i++) apb(1'b0, 8'h14, 32'h0);
    chk(q[5], 1'b1);
    wait_done();
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0041);
    apb(1'b1, 8'h14, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    chk(q[1], 1'b0);
    ack_dly <= 8'h1e;
    $display("slow ack test done");
  endtask

  task automatic t_lock();
    fetch <= 1'b1;
    mul_n <= 1'b0;
    repeat (30) @(posedge clk);
    go(16'h0050, 16'h0050, 8'h19);
    repeat (60) @(posedge clk);
    apb(1'b0, 8'h14, 32'h0);
    chk(q[4], 1'b1);
    chk({idle_n, 31'(n_mc)}, 32'h80000000);
    mul_n <= 1'b1;
    div_n <= 1'b0;
    repeat (60) @(posedge clk);
    chk(idle_n, 1'b1);
    div_n <= 1'b1;
    wait_done();
    chk(n_mc, 1);
    fetch <= 1'b0;
    $display("lockout test done");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    quiet = 1'b0;
    fetch = 1'b0;
    mul_n = 1'b1;
    div_n = 1'b1;
    ack_dly = 8'h1e;
    acked = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_read();
    t_write();
    t_quiet();
    t_slow();
    t_lock();
    results();
  end
endmodule
